/* rbc_board.sv */
`timescale 1ns/100ps
`default_nettype none
module rbc_board (
    input  wire logic       clock,
    input  wire logic       resetn,
    input  wire logic [3:0] strapVal,
    output var  logic [3:0] strapPins
);
    logic [3:0] holdCnt_r;
    ////////////////////////////////////////////////////////////
    // Straps driven in reset and a short hold; once freed the pins
    // churn every cycle so a late sample of them shows up at once
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            holdCnt_r <= 4'h0;
            strapPins <= strapVal;
        end else if (holdCnt_r != 4'hC) begin
            holdCnt_r <= holdCnt_r + 4'h1;
        end else begin
            strapPins <= ~strapPins;
        end
    end
endmodule // rbc_board
`default_nettype wire

/* rbc_ctl.v */
`timescale 1ns/100ps
`default_nettype none
`include "rbc_regs.vh"

module rbc_ctl (
    input  wire        clock,
    input  wire        resetn,
    // AXI4-Lite slave
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Board pins
    input  wire        modeAPin,
    input  wire        modeBPin,
    input  wire        modeCFlagTwoPin,
    input  wire        modeDPin,
    input  wire        busRequestPin,
    output reg         hostAccessAckOut,
    output reg         hostAccessAckOe,
    output reg         cycleClockOut,
    // Core side
    input  wire        irqPending,
    input  wire        byteDmaWordDone,
    input  wire        hostDmaPmZeroWrite,
    output reg         divClockTick,
    output reg         execHold,
    output reg         runStart,
    output reg  [15:0] startAddr,
    output reg         startExternal,
    output reg         hostMode,
    output reg  [13:0] extAddrMask,
    output reg         byteDmaBootReq,
    output reg         stackReset,
    output reg         irqMaskAll,
    output reg         modeStatusClear,
    output reg         idleWake
);

////////////////////////////////////////////////////////////////////////////////
localparam [2:0] ST_STRAP = 3'h0;
localparam [2:0] ST_BUSW  = 3'h1;
localparam [2:0] ST_BYTE_MEMORY_DMA  = 3'h2;
localparam [2:0] ST_HOST_PORT_DMA  = 3'h3;
localparam [2:0] ST_RUN   = 3'h4;
localparam [1:0] ID_RUN   = 2'h0;
localparam [1:0] ID_STD   = 2'h1;
localparam [1:0] ID_SLOW  = 2'h2;

// Divisor from idle code; zero means standard idle
function [7:0] divOf;
    input [2:0] code;
    begin
        case (code)
            3'h1:    divOf = `RBC_DIV_16;
            3'h2:    divOf = `RBC_DIV_32;
            3'h3:    divOf = `RBC_DIV_64;
            3'h4:    divOf = `RBC_DIV_128;
            default: divOf = 8'h00;
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Reset release through two flops; clock never stops, so no settle wait
reg rstMeta_r;
reg rstn_r;
always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
        rstMeta_r <= 1'b0;
        rstn_r    <= 1'b0;
    end else begin
        rstMeta_r <= 1'b1;
        rstn_r    <= rstMeta_r;
    end
end

// Pin synchronisers, three stages; only stages two and three are looked at
reg [4:0] pinS1_r;
reg [4:0] pinS2_r;
reg [4:0] pinS3_r;
reg [4:0] pinQ_r;
always @(posedge clock or negedge rstn_r) begin
    if (!rstn_r) begin
        pinS1_r <= 5'h00;
        pinS2_r <= 5'h00;
        pinS3_r <= 5'h00;
        pinQ_r  <= 5'h00;
    end else begin
        pinS1_r <= {busRequestPin, modeDPin, modeCFlagTwoPin, modeBPin, modeAPin};
        pinS2_r <= pinS1_r;
        pinS3_r <= pinS2_r;
        pinQ_r  <= (pinQ_r & ~(pinS2_r ^ pinS3_r)) | (pinS2_r & ~(pinS2_r ^ pinS3_r));
    end
end
wire busReq = pinQ_r[4];

////////////////////////////////////////////////////////////////////////////////
// Register bus: write address and data taken in either order
reg        awHeld_r;
reg        wHeld_r;
reg [7:0]  awAddr_r;
reg [31:0] wData_r;
reg [3:0]  wStrb_r;
reg        clkOutDis_r;
reg        idleReq_r;
reg [2:0]  idleCode_r;
wire       wrGo = awHeld_r && wHeld_r && !s_axi_bvalid;

always @(posedge clock or negedge rstn_r) begin
    if (!rstn_r) begin
        awHeld_r      <= 1'b0;
        wHeld_r       <= 1'b0;
        awAddr_r      <= 8'h00;
        wData_r       <= 32'h0000_0000;
        wStrb_r       <= 4'h0;
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
        s_axi_bvalid  <= 1'b0;
        s_axi_bresp   <= `RBC_RESP_OKAY;
        clkOutDis_r   <= `RBC_RST_CYCLE_CLOCK_OUT_DIS;
        idleReq_r     <= 1'b0;
        idleCode_r    <= 3'h0;
    end else begin
        idleReq_r     <= 1'b0;
        s_axi_awready <= !awHeld_r && !s_axi_awready;
        s_axi_wready  <= !wHeld_r && !s_axi_wready;
        if (s_axi_awvalid && s_axi_awready) begin
            awHeld_r      <= 1'b1;
            awAddr_r      <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wHeld_r      <= 1'b1;
            wData_r      <= s_axi_wdata;
            wStrb_r      <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end
        if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
        // Commit and answer once both halves are in
        if (wrGo) begin
            awHeld_r     <= 1'b0;
            wHeld_r      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= `RBC_RESP_OKAY;
            case (awAddr_r)
                `RBC_OFS_SERIAL_PORT_ZERO_CTRL: begin
                    if (wStrb_r[0])
                        clkOutDis_r <= wData_r[`RBC_BIT_CYCLE_CLOCK_OUT_DIS];
                end
                `RBC_OFS_IDLE_CMD: begin
                    if (wStrb_r[0]) begin
                        idleReq_r  <= 1'b1;
                        idleCode_r <= wData_r[`RBC_IDLE_CODE_LSB +: `RBC_IDLE_CODE_W];
                    end
                end
                `RBC_OFS_STATUS: ;
                default:
                    s_axi_bresp <= `RBC_RESP_SLVERR;
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Strap latch and boot sequencing
reg [2:0] bootSt_r;
reg [2:0] settle_r;
reg [3:0] strap_r;
reg [5:0] bootCnt_r;
reg [1:0] idleSt_r;

// Decode of latched straps {D,C,B,A}
wire strapBdma = !strap_r[1] && !strap_r[0] && !(strap_r[2] && strap_r[1]);
wire strapIdma = strap_r[2] && !strap_r[1] && strap_r[0];

always @(posedge clock or negedge rstn_r) begin
    if (!rstn_r) begin
        bootSt_r         <= ST_STRAP;
        settle_r         <= 3'h0;
        strap_r          <= 4'h0;
        bootCnt_r        <= 6'h00;
        execHold         <= 1'b1;
        runStart         <= 1'b0;
        startAddr        <= `RBC_BOOT_PC;
        startExternal    <= 1'b0;
        hostMode         <= 1'b0;
        extAddrMask      <= 14'h3FFF;
        byteDmaBootReq   <= 1'b0;
        hostAccessAckOut <= 1'b0;
        hostAccessAckOe  <= 1'b0;
        stackReset       <= 1'b1;
        irqMaskAll       <= 1'b1;
        modeStatusClear  <= 1'b1;
    end else begin
        runStart <= 1'b0;
        case (bootSt_r)
            ST_STRAP: begin
                // Sync stages fill first; straps frozen after this
                // One count more than the sync depth, so the agreed copy is already in
                if (settle_r != `RBC_STRAP_SETTLE) begin
                    settle_r <= settle_r + 3'h1;
                end else begin
                    strap_r  <= pinQ_r[3:0];
                    bootSt_r <= ST_BUSW;
                end
            end
            ST_BUSW: begin
                hostMode    <= strap_r[2];
                extAddrMask <= strap_r[2] ? 14'h0001 : 14'h3FFF;
                // Active pull-down on host ack only with strap D low
                hostAccessAckOe <= strap_r[2] && !strap_r[3];
                // Boot waits out any pending bus request
                if (!busReq) begin
                    if (strapBdma) begin
                        byteDmaBootReq <= 1'b1;
                        bootSt_r       <= ST_BYTE_MEMORY_DMA;
                    end else if (strapIdma) begin
                        bootSt_r <= ST_HOST_PORT_DMA;
                    end else begin
                        startExternal <= 1'b1;
                        execHold      <= 1'b0;
                        runStart      <= 1'b1;
                        bootSt_r      <= ST_RUN;
                    end
                end
            end
            ST_BYTE_MEMORY_DMA: begin
                if (byteDmaWordDone)
                    bootCnt_r <= bootCnt_r + 6'h01;
                if (byteDmaWordDone && bootCnt_r == `RBC_BOOT_WORDS - 6'h01) begin
                    byteDmaBootReq <= 1'b0;
                    execHold       <= 1'b0;
                    startAddr      <= `RBC_BOOT_PC;
                    runStart       <= 1'b1;
                    bootSt_r       <= ST_RUN;
                end
            end
            ST_HOST_PORT_DMA: begin
                if (hostDmaPmZeroWrite) begin
                    execHold  <= 1'b0;
                    startAddr <= `RBC_BOOT_PC;
                    runStart  <= 1'b1;
                    bootSt_r  <= ST_RUN;
                end
            end
            ST_RUN: begin
                stackReset      <= 1'b0;
                irqMaskAll      <= 1'b0;
                modeStatusClear <= 1'b0;
            end
            default:
                bootSt_r <= ST_STRAP;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// Idle control and clock division
reg  [7:0] divN_r;
reg  [7:0] divCnt_r;
reg        irqSeen_r;
wire       slowTick = (divCnt_r == divN_r - 8'h01);

always @(posedge clock or negedge rstn_r) begin
    if (!rstn_r) begin
        idleSt_r     <= ID_RUN;
        divN_r       <= 8'h00;
        divCnt_r     <= 8'h00;
        irqSeen_r    <= 1'b0;
        idleWake     <= 1'b0;
        divClockTick <= 1'b0;
    end else begin
        idleWake <= 1'b0;
        case (idleSt_r)
            ID_RUN: begin
                divClockTick <= 1'b1;
                divCnt_r     <= 8'h00;
                irqSeen_r    <= 1'b0;
                if (idleReq_r && bootSt_r == ST_RUN) begin
                    divN_r   <= divOf(idleCode_r);
                    idleSt_r <= (divOf(idleCode_r) == 8'h00) ? ID_STD : ID_SLOW;
                end
            end
            ID_STD: begin
                // Undivided clock, wake on the cycle after the interrupt
                divClockTick <= 1'b1;
                if (irqPending) begin
                    idleWake <= 1'b1;
                    idleSt_r <= ID_RUN;
                end
            end
            ID_SLOW: begin
                // One tick per n cycles feeds core, serial, timer, clock out
                divCnt_r     <= slowTick ? 8'h00 : divCnt_r + 8'h01;
                divClockTick <= slowTick;
                if (irqPending)
                    irqSeen_r <= 1'b1;
                // Wake only on a divided edge, hence up to n cycles late
                if ((irqPending || irqSeen_r) && slowTick) begin
                    idleWake     <= 1'b1;
                    divClockTick <= 1'b1;
                    idleSt_r     <= ID_RUN;
                end
            end
            default:
                idleSt_r <= ID_RUN;
        endcase
    end
end

// Cycle clock out toggles on each processor tick; held low when disabled
always @(posedge clock or negedge rstn_r) begin
    if (!rstn_r)
        cycleClockOut <= 1'b0;
    else if (clkOutDis_r)
        cycleClockOut <= 1'b0;
    else if (divClockTick)
        cycleClockOut <= !cycleClockOut;
end

////////////////////////////////////////////////////////////////////////////////
// Register reads; unmapped answers SLVERR with zero data
always @(posedge clock or negedge rstn_r) begin
    if (!rstn_r) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b0;
        s_axi_rdata   <= 32'h0000_0000;
        s_axi_rresp   <= `RBC_RESP_OKAY;
    end else begin
        s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
        if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
        if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `RBC_RESP_OKAY;
            case (s_axi_araddr)
                `RBC_OFS_SERIAL_PORT_ZERO_CTRL: s_axi_rdata <= {31'h0, clkOutDis_r};
                `RBC_OFS_IDLE_CMD:    s_axi_rdata <= {29'h0, idleCode_r};
                `RBC_OFS_STATUS:      s_axi_rdata <= {8'h00, divN_r, 6'h00, idleSt_r, 2'h0,
                                                      bootSt_r == ST_RUN, strap_r[2],
                                                      strap_r[3:0]};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `RBC_RESP_SLVERR;
                end
            endcase
        end
    end
end

endmodule // rbc_ctl
`default_nettype wire

/* rbc_ctl_props.sv */
`timescale 1ns/100ps
`default_nettype none
// Pin-level watch on the reset, boot and clock control block
module rbc_ctl_chk (
    input wire logic        clock,
    input wire logic        resetn,
    input wire logic        hostAccessAckOut,
    input wire logic        hostAccessAckOe,
    input wire logic        hostMode,
    input wire logic [13:0] extAddrMask,
    input wire logic        runStart,
    input wire logic [15:0] startAddr,
    input wire logic        execHold,
    input wire logic        stackReset,
    input wire logic        irqMaskAll,
    input wire logic        modeStatusClear,
    input wire logic        byteDmaBootReq,
    input wire logic        divClockTick,
    input wire logic        cycleClockOut,
    input wire logic        irqPending,
    input wire logic        idleWake
);
    logic [7:0] gapCnt_r;
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////
    // Gap between divided ticks; boot time is left out on purpose
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            gapCnt_r <= 8'h00;
        end else begin
            gapCnt_r <= (!divClockTick && !execHold) ? gapCnt_r + 8'h01 : 8'h00;
        end
    end
    ////////////////////////////////////////////////////////////
    // Pin and mode relations
    property p_ack;
        hostAccessAckOe |-> hostMode && !hostAccessAckOut;
    endproperty
    a_ack: assert property (p_ack) else $error("host ack pulled outside host mode");
    property p_mask;
        extAddrMask == (hostMode ? 14'h0001 : 14'h3FFF);
    endproperty
    a_mask: assert property (p_mask) else $error("address mask wrong for mode");
    property p_start;
        runStart |-> (startAddr == 16'h0000) ##1 !runStart;
    endproperty
    a_start: assert property (p_start) else $error("bad first fetch");
    property p_hold;
        execHold |-> stackReset && irqMaskAll && modeStatusClear;
    endproperty
    a_hold: assert property (p_hold) else $error("reset effects dropped early");
    property p_dma;
        byteDmaBootReq |-> execHold;
    endproperty
    a_dma: assert property (p_dma) else $error("ran during boot load");
    property p_latch;
        !execHold ##1 !execHold |-> $stable(hostMode) && $stable(extAddrMask);
    endproperty
    a_latch: assert property (p_latch) else $error("mode moved while running");
    ////////////////////////////////////////////////////////////
    // Slowed clocks and wake-up
    property p_gap;
        gapCnt_r <= 8'h80;
    endproperty
    a_gap: assert property (p_gap) else $error("tick gap too long");
    property p_cco;
        !divClockTick [*3] |-> $stable(cycleClockOut);
    endproperty
    a_cco: assert property (p_cco) else $error("clock out not divided");
    property p_irq;
        irqPending && !divClockTick && !execHold |-> ##[0:128] idleWake;
    endproperty
    a_irq: assert property (p_irq) else $error("slow idle wake too late");
    property p_wake;
        idleWake |=> divClockTick [*2];
    endproperty
    a_wake: assert property (p_wake) else $error("clock still divided after wake");
endmodule // rbc_ctl_chk

bind rbc_ctl rbc_ctl_chk chk_u (
    .clock(clock), .resetn(resetn), .hostAccessAckOut(hostAccessAckOut),
    .hostAccessAckOe(hostAccessAckOe), .hostMode(hostMode), .extAddrMask(extAddrMask),
    .runStart(runStart), .startAddr(startAddr), .execHold(execHold), .stackReset(stackReset),
    .irqMaskAll(irqMaskAll), .modeStatusClear(modeStatusClear), .byteDmaBootReq(byteDmaBootReq),
    .divClockTick(divClockTick), .cycleClockOut(cycleClockOut), .irqPending(irqPending),
    .idleWake(idleWake)
);
`default_nettype wire

/* rbc_regs.vh */
// Contract
// - Slow idle divides serial, cycle-clock-out and timer clocks by the core divisor n.
// - Idle with no divisor is standard idle; core clock stays undivided.
// - Slow idle with n of 16/32/64/128 exits within n cycles of an interrupt.
// - Standard idle wakes one cycle after an interrupt; slow idle takes n times longer.
// - Host memory mode drives the full data bus but only the lowest address bit.
// - Instruction cycle runs at twice the oscillator rate, one instruction per cycle.
// - Cycle-rate clock output is gated by a disable bit in serial port zero control.
// - Reset after power-up keeps the clock running; no stabilisation wait on release.
// - Master reset empties stacks, masks every interrupt, clears mode status register.
// - On release, boot runs only with no bus request pending and a booting strap.
// - After boot the first fetch is on-chip program memory address 0x0000.
// - Memory mode comes from strap C during reset, shared with flag two pin.
// - Straps C,B,A low: byte DMA loads 32 words, execution held, full memory mode.
// - Straps C0 B1 A0: no boot, execute from external 0, full memory mode.
// - Straps C1 B0 A1: host mode, held until host DMA writes program address 0.
// - Host boot: device pulls host ack low when strap D low; else board pull-down.
`ifndef RBC_REGS_VH
`define RBC_REGS_VH
`define RBC_OFS_SERIAL_PORT_ZERO_CTRL 8'h00
`define RBC_OFS_IDLE_CMD    8'h04
`define RBC_OFS_STATUS      8'h08
`define RBC_BIT_CYCLE_CLOCK_OUT_DIS  0
`define RBC_RST_CYCLE_CLOCK_OUT_DIS  1'b0
`define RBC_IDLE_CODE_LSB   0
`define RBC_IDLE_CODE_W     3
`define RBC_DIV_16          8'h10
`define RBC_DIV_32          8'h20
`define RBC_DIV_64          8'h40
`define RBC_DIV_128         8'h80
`define RBC_BOOT_WORDS      6'h20
`define RBC_BOOT_PC         16'h0000
`define RBC_STRAP_SETTLE    3'h4
`define RBC_RESP_OKAY       2'h0
`define RBC_RESP_SLVERR     2'h2
`endif

/* reset_boot_mode_clock_ctl_bench.sv */
`timescale 1ns/100ps
`default_nettype none
`include "rbc_regs.vh"
module reset_boot_mode_clock_ctl_bench;
    logic        clock, resetn, awvalid, wvalid, bready, arvalid, rready, busReq, prev;
    logic        awready, wready, bvalid, arready, rvalid, irqPending, wordDone, pmZeroWr;
    logic        ackOut, ackOe, cco, tick, execHold, runStart, startExt, hostMode;
    logic        dmaReq, stackRst, maskAll, mstClr, idleWake;
    logic [1:0]  bresp, rresp;
    logic [3:0]  strapVal, strapPins, wstrb, obs;
    logic [7:0]  awaddr, araddr;
    logic [13:0] addrMask;
    logic [15:0] startAddr;
    logic [31:0] wdata, rdata, seed;
    logic [33:0] expQ[$];
    int          miscompares, checks_done, n, div;
    assign obs = {tick, dmaReq, idleWake, runStart};
    rbc_ctl dut_u (
        .clock(clock), .resetn(resetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .modeAPin(strapPins[0]), .modeBPin(strapPins[1]), .modeCFlagTwoPin(strapPins[2]),
        .modeDPin(strapPins[3]), .busRequestPin(busReq), .hostAccessAckOut(ackOut),
        .hostAccessAckOe(ackOe), .cycleClockOut(cco), .irqPending(irqPending),
        .byteDmaWordDone(wordDone), .hostDmaPmZeroWrite(pmZeroWr), .divClockTick(tick),
        .execHold(execHold), .runStart(runStart), .startAddr(startAddr), .startExternal(startExt),
        .hostMode(hostMode), .extAddrMask(addrMask), .byteDmaBootReq(dmaReq),
        .stackReset(stackRst), .irqMaskAll(maskAll), .modeStatusClear(mstClr), .idleWake(idleWake)
    );
    rbc_board board_u (.clock(clock), .resetn(resetn), .strapVal(strapVal), .strapPins(strapPins));
    ////////////////////////////////////////////////////////////
    // Free-running source, never stopped
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    task automatic test_done;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic hang;
        miscompares++;
        test_done;
    endtask
    // Empty queue means an answer nobody asked for
    task automatic pop(input logic [33:0] s);
        if (expQ.size() == 0) chk(s, ~s);
        else chk(s, expQ.pop_front());
    endtask
    task automatic waitOn(input int i);
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (obs[i] !== 1'b1 && n < 3000);
        if (n >= 3000) hang;
    endtask
    ////////////////////////////////////////////////////////////
    // Bus master; address and data offered together
    task automatic axWr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        expQ.push_back({r, 32'h0});
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'($random(seed)) | 4'h1;
        {awvalid, wvalid, bready} <= 3'h7;
        n = 0;
        do begin
            @(posedge clock);
            n++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 100);
        bready <= 1'b0;
        if (n >= 100) hang;
        @(posedge clock);
    endtask
    task automatic axRd(input logic [7:0] a, input logic [33:0] e);
        expQ.push_back(e);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        n = 0;
        do begin
            @(posedge clock);
            n++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 100);
        rready <= 1'b0;
        if (n >= 100) hang;
        @(posedge clock);
    endtask
    // Results in arrival order against the oldest note
    always @(posedge clock) begin
        if (bvalid === 1'b1 && bready) pop({bresp, 32'h0});
        if (rvalid === 1'b1 && rready) pop({rresp, rdata & 32'h0000033F});
        if (runStart === 1'b1) pop({15'h0, startExt, hostMode, ackOe, startAddr});
    end
    ////////////////////////////////////////////////////////////
    // Reset with given straps, then feed the boot it asks for
    task automatic boot(input logic [3:0] s, input logic pend);
        strapVal <= s;
        @(posedge clock);
        resetn <= 1'b0;
        busReq <= pend;
        // First reset stands for power-up: 2000 oscillator clocks, two cycles each
        repeat (checks_done == 0 ? 4000 : 2) @(posedge clock);
        chk({execHold, stackRst, maskAll, mstClr}, 4'hF);
        resetn <= 1'b1;
        expQ.push_back({15'h0, s[2:0] == 3'b010, s[2], s[2] & !s[3], 16'h0000});
        if (pend) begin
            repeat (20) @(posedge clock);
            chk({dmaReq, execHold}, 2'b01);
            busReq <= 1'b0;
        end
        if (s[1:0] == 2'b00) begin
            waitOn(2);
            for (int k = 0; k < 32; k++) begin
                repeat ({$random(seed)} % 3 + 1) @(posedge clock);
                chk(execHold, 1'b1);
                wordDone <= 1'b1;
                @(posedge clock);
                wordDone <= 1'b0;
            end
        end else if (s[0]) begin
            repeat (20) @(posedge clock);
            chk(execHold, 1'b1);
            pmZeroWr <= 1'b1;
            @(posedge clock);
            pmZeroWr <= 1'b0;
        end
        waitOn(0);
        axRd(`RBC_OFS_STATUS, {28'h1, s[2], s});
        $display("boot with straps %b done", s);
    endtask
    // Raise an interrupt in idle and time the wake
    task automatic wake(input int lo, input int hi);
        irqPending <= 1'b1;
        waitOn(1);
        irqPending <= 1'b0;
        chk(n >= lo && n <= hi, 1'b1);
        repeat (3) begin
            @(posedge clock);
            chk(tick, 1'b1);
        end
    endtask
    ////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        seed = 32'h9FE0D214;
        {resetn, busReq, irqPending, wordDone, pmZeroWr, awvalid, wvalid, bready, arvalid, rready} = '0;
        {strapVal, awaddr, araddr, wdata, wstrb} = '0;
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        boot(4'b0000, 1'b1);
        boot(4'b0100, 1'b0);
        boot(4'b0101, 1'b0);
        boot(4'b1101, 1'b0);
        boot(4'b1100, 1'b0);
        boot(4'b0010, 1'b0);
        axRd(`RBC_OFS_SERIAL_PORT_ZERO_CTRL, 34'h0);
        axWr(`RBC_OFS_SERIAL_PORT_ZERO_CTRL, $random(seed) | 32'h1, `RBC_RESP_OKAY);
        repeat (8) begin
            @(posedge clock);
            chk(cco, 1'b0);
        end
        axRd(`RBC_OFS_SERIAL_PORT_ZERO_CTRL, 34'h1);
        axWr(`RBC_OFS_SERIAL_PORT_ZERO_CTRL, 32'h0, `RBC_RESP_OKAY);
        repeat (3) @(posedge clock);
        prev = cco;
        @(posedge clock);
        chk(cco, !prev);
        axWr(8'h0C, $random(seed), `RBC_RESP_SLVERR);
        axRd(8'h0C, {`RBC_RESP_SLVERR, 32'h0});
        axWr(`RBC_OFS_STATUS, 32'hFFFFFFFF, `RBC_RESP_OKAY);
        axRd(`RBC_OFS_STATUS, 34'h22);
        $display("register map done");
        axWr(`RBC_OFS_IDLE_CMD, 32'h0, `RBC_RESP_OKAY);
        repeat (8) begin
            @(posedge clock);
            chk(tick, 1'b1);
        end
        wake(2, 2);
        for (int c = 1; c < 5; c++) begin
            div = 8 << c;
            axWr(`RBC_OFS_IDLE_CMD, c, `RBC_RESP_OKAY);
            axRd(`RBC_OFS_IDLE_CMD, 34'(c));
            waitOn(3);
            waitOn(3);
            chk(34'(n), 34'(div));
            repeat ({$random(seed)} % div) @(posedge clock);
            wake(1, div + 1);
        end
        $display("idle modes done");
        test_done;
    end
endmodule // reset_boot_mode_clock_ctl_bench
`default_nettype wire
